// ===== acc_cfg.svh
// acc_cfg.svh: constants for the converter control block.
// assumes a 100 MHz core clock; included by the package, acc_out_drv and acc_ctrl.
`ifndef ACC_CFG_SVH
`define ACC_CFG_SVH
`define ACC_CLK_PERIOD_NS 10
`define ACC_BITS_FULL 12
`define ACC_BITS_SHORT 8
`define ACC_CYC_PER_BIT 95
`define ACC_ACQ_TIME_NS 1400
`define ACC_ACQ_CYC ((`ACC_ACQ_TIME_NS + `ACC_CLK_PERIOD_NS - 1) / `ACC_CLK_PERIOD_NS)
`define ACC_SHORT_BIT_POS 4
`define ACC_MARK_BIT_POS 3
`endif

// ===== acc_pkg.sv
// acc_pkg.sv: types shared by the converter control modules.
// assumes acc_cfg.svh is on the include path.
`include "acc_cfg.svh"
package acc_pkg;
  typedef logic [`ACC_BITS_FULL-1:0] acc_word_t;
  typedef enum logic [1:0] {
    ACC_IDLE = 2'b00,
    ACC_CONV = 2'b01
  } acc_state_t;
endpackage

// ===== acc_out_drv.sv
// acc_out_drv.sv: output enable and data formatting for the three-state bus.
// assumes its inputs are registered in the parent; outputs are registered here.
`timescale 1ns/1ns
`include "acc_cfg.svh"
module acc_out_drv
  import acc_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // read request
  input wire logic read_en_i,
  input wire logic width_full_i,
  input wire logic byte_length_select_i,
  input wire acc_pkg::acc_word_t result_i,
  // pins
  output logic [`ACC_BITS_FULL-1:0] data_o,
  output logic [`ACC_BITS_FULL-1:0] data_oe_o
);
  typedef struct packed {
    logic [`ACC_BITS_FULL-1:0] data;
    logic [`ACC_BITS_FULL-1:0] oe;
  } acc_od_t;
  acc_od_t st;
  acc_od_t next_st;
  logic [`ACC_BITS_FULL-1:0] want_oe;
  logic [`ACC_BITS_FULL-1:0] want_data;

  // target enables per the read format
  always_comb begin
    want_oe = 12'h000;
    want_data = 12'h000;
    if (read_en_i) begin
      if (width_full_i) begin
        want_oe = 12'hfff;
        want_data = result_i;
      end else if (!byte_length_select_i) begin
        want_oe = 12'hff0;
        want_data = result_i;
      end else begin
        want_oe = 12'h0ff;
        want_data = {4'h0, 4'h0, result_i[3:0]};
      end
    end
  end

  // any pin whose enable would be dropped releases first; new ones wait a cycle
  always_comb begin
    next_st = st;
    next_st.data = want_data;
    if ((st.oe & ~want_oe) != 12'h000) begin
      next_st.oe = st.oe & want_oe;
    end else begin
      next_st.oe = want_oe;
    end
    if (!rst_n_i) begin
      next_st = '0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    st <= next_st;
  end

  assign data_o = st.data;
  assign data_oe_o = st.oe;

  bytes_apart_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !(st.oe[11:8] != 4'h0 && st.oe[3:0] != 4'h0 && st.oe[7:4] != 4'hf))
    else $error("both bytes driven at once");
  low_byte_zero_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (st.oe == 12'h0ff) |-> (st.data[7:4] == 4'h0))
    else $error("bits 4 to 7 not zero");
endmodule // acc_out_drv

// ===== acc_ctrl.sv
// acc_ctrl.sv: conversion start, busy flag, sampler control and read gating.
// assumes all control pins are synchronous to core_clk_i; the analog result
// arrives on sar_bit_i one bit per step, msb first, while the block converts.
//
// Notes on behaviour
// - start captures length select; 8 or 12
// - last of three enables starts conversion
// - short result reads bit three high
// - busy flag high only while converting
// - busy keeps all outputs floating from its second cycle
// - start during busy never restarts
// - start during busy recaptures length select
// - outputs enabled only on valid read
// - width select high drives twelve bits
// - byte mode, select low: upper eight
// - byte mode, select high: nibble, zeros
// - release one byte before enabling other
// - length select may toggle any time
// - start command also raises hold
// - sampler tracks again once conversion ends
// - sample taken at command, input free after
`timescale 1ns/1ns
`include "acc_cfg.svh"
module acc_ctrl
  import acc_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // control pins
  input wire logic chip_enable_i,
  input wire logic chip_select_n_i,
  input wire logic read_convert_i,
  input wire logic width_full_i,
  input wire logic byte_length_select_i,
  // successive approximation comparator decision
  input wire logic sar_bit_i,
  // status and sampler
  output logic conversion_busy_flag_o,
  output logic hold_o,
  // data pins
  output logic [`ACC_BITS_FULL-1:0] data_o,
  output logic [`ACC_BITS_FULL-1:0] data_oe_o
);
  typedef struct packed {
    acc_state_t state;
    logic start_cond;
    logic short_len;
    logic [6:0] cyc;
    logic [3:0] bit_cnt;
    acc_word_t shreg;
    acc_word_t result;
    logic busy;
    logic hold;
    logic read_en;
    logic width_full;
    logic bls;
  } acc_st_t;
  acc_st_t st;
  acc_st_t next_st;
  logic start_now;
  logic start_edge;
  logic [3:0] bits_needed;

  // start condition as a level; its rising edge is the start, so whichever
  // input arrives last fires it
  assign start_now = chip_enable_i && !chip_select_n_i && !read_convert_i;
  assign start_edge = start_now && !st.start_cond;
  assign bits_needed = st.short_len ? 4'(`ACC_BITS_SHORT) : 4'(`ACC_BITS_FULL);

  // timing of one conversion, in core clock edges after the start edge:
  // the flag and the hold rise together on the start edge itself; each
  // result bit then takes a fixed count of cycles, the comparator decision
  // being shifted in on the last cycle of its period; the step after the
  // last bit loads the result and drops flag and hold in the same edge.
  // a short conversion stops after eight bits and so ends early by four
  // bit periods. a start seen while busy only moves the captured length:
  // if it shortens a conversion that is already past eight bits, the very
  // next step completes it, a hazard of changing the length select while
  // converting that is left to the host to avoid.
  // the cycle counter stays put while idle, so nothing runs between
  // conversions and the sampler is free to track.

  always_comb begin
    next_st = st;
    next_st.start_cond = start_now;
    next_st.width_full = width_full_i;
    // select tracked freely, no side effect
    next_st.bls = byte_length_select_i;
    case (st.state)
      ACC_IDLE: begin
        if (start_edge) begin
          next_st.short_len = byte_length_select_i;
          next_st.hold = 1'b1;
          next_st.busy = 1'b1;
          next_st.cyc = 7'h00;
          next_st.bit_cnt = 4'h0;
          next_st.shreg = 12'h000;
          next_st.state = ACC_CONV;
        end
      end
      ACC_CONV: begin
        if (start_edge) begin
          next_st.short_len = byte_length_select_i;
        end
        // each bit takes a fixed cycle count
        if (st.cyc == 7'(`ACC_CYC_PER_BIT - 1)) begin
          next_st.cyc = 7'h00;
          next_st.shreg = {st.shreg[10:0], sar_bit_i};
          next_st.bit_cnt = st.bit_cnt + 4'h1;
        end else begin
          next_st.cyc = st.cyc + 7'h01;
        end
        if (st.bit_cnt >= bits_needed) begin
          if (st.short_len) begin
            // short result: marker bit one, tail zero
            next_st.result = {st.shreg[7:0], 4'b1000};
          end else begin
            next_st.result = st.shreg;
          end
          next_st.hold = 1'b0;
          next_st.busy = 1'b0;
          next_st.state = ACC_IDLE;
        end
      end
      default: begin
        next_st.state = ACC_IDLE;
      end
    endcase
    next_st.read_en = read_convert_i && chip_enable_i && !chip_select_n_i
                      && !next_st.busy;
    if (!rst_n_i) begin
      next_st = '0;
      next_st.state = ACC_IDLE;
    end
  end

  always_ff @(posedge core_clk_i) begin
    st <= next_st;
  end

  // three-state formatting with byte break-before-make
  acc_out_drv u_out (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .read_en_i(st.read_en),
    .width_full_i(st.width_full),
    .byte_length_select_i(st.bls),
    .result_i(st.result),
    .data_o(data_o),
    .data_oe_o(data_oe_o)
  );

  assign conversion_busy_flag_o = st.busy;
  assign hold_o = st.hold;

  // checks of the control state; all on the core clock, reset disables them

  busy_state_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    st.busy == (st.state == ACC_CONV))
    else $error("busy flag disagrees with state");

  busy_float_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    st.busy |-> ##1 (data_oe_o == 12'h000))
    else $error("outputs driven while busy");

  no_restart_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (st.state == ACC_CONV && start_edge && st.cyc != 7'(`ACC_CYC_PER_BIT - 1))
    |=> (st.cyc == $past(st.cyc) + 7'h01))
    else $error("conversion restarted");

  start_conv_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (st.state == ACC_IDLE && start_edge) |=> (st.busy && st.hold))
    else $error("start not taken");

  len_capture_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (st.state == ACC_IDLE && start_edge) |=> (st.short_len == $past(byte_length_select_i)))
    else $error("length select not captured");

  track_after_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    $fell(st.busy) |-> !st.hold)
    else $error("sampler still holding");

  short_mark_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    ($fell(st.busy) && st.short_len) |-> (st.result[3:0] == 4'b1000))
    else $error("short result tail wrong");

  read_gate_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !st.read_en |=> (data_oe_o == 12'h000))
    else $error("outputs driven without read");

  hold_busy_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    st.hold == st.busy)
    else $error("hold and busy disagree");

  hold_rise_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    $rose(st.hold) |-> ($past(start_edge) && ($past(st.state) == ACC_IDLE)))
    else $error("hold rose without a start");

  busy_rise_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    $rose(st.busy) |-> $past(start_now))
    else $error("busy rose without start condition");

  recapture_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (st.state == ACC_CONV && start_edge) |=> (st.short_len == $past(byte_length_select_i)))
    else $error("length select not recaptured");

  no_rewind_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (st.state == ACC_CONV && start_edge) |=> (st.bit_cnt >= $past(st.bit_cnt)))
    else $error("bit count reset by a start");

  shreg_keep_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (st.state == ACC_CONV && start_edge && st.cyc != 7'(`ACC_CYC_PER_BIT - 1))
    |=> (st.shreg == $past(st.shreg)))
    else $error("partial result lost on a start");

  cyc_range_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    st.cyc < 7'(`ACC_CYC_PER_BIT))
    else $error("cycle counter out of range");

  bit_cap_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    st.bit_cnt <= 4'(`ACC_BITS_FULL))
    else $error("bit counter out of range");

  done_ends_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (st.state == ACC_CONV && st.bit_cnt >= bits_needed) |=> (!st.busy && !st.hold))
    else $error("busy did not fall at completion");

  busy_no_read_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    st.busy |-> !st.read_en)
    else $error("read gate open while busy");

  read_cond_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    st.read_en |-> ($past(read_convert_i) && $past(chip_enable_i) && !$past(chip_select_n_i)))
    else $error("read gate open without read inputs");

  read_take_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (read_convert_i && chip_enable_i && !chip_select_n_i && st.state == ACC_IDLE)
    |=> st.read_en)
    else $error("read gate stayed shut");

  idle_quiet_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (st.state == ACC_IDLE && !start_edge) |=> !st.busy)
    else $error("busy rose while idle");

  // length only moves on a start
  len_hold_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !start_edge |=> (st.short_len == $past(st.short_len)))
    else $error("length changed without a start");

  bls_track_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    1'b1 |=> (st.bls == $past(byte_length_select_i)))
    else $error("select copy lags the pin");

  width_track_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    1'b1 |=> (st.width_full == $past(width_full_i)))
    else $error("width copy lags the pin");

  idle_keep_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (st.state == ACC_IDLE && !start_edge) |=> (st.shreg == $past(st.shreg)))
    else $error("result register moved while idle");

  start_clear_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (st.state == ACC_IDLE && start_edge) |=> (st.bit_cnt == 4'h0 && st.cyc == 7'h00))
    else $error("counters not cleared at start");

  short_run_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (st.state == ACC_CONV && st.short_len && st.bit_cnt < 4'(`ACC_BITS_SHORT))
    |=> st.busy)
    else $error("short conversion ended early");

  full_run_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (st.state == ACC_CONV && !st.short_len && st.bit_cnt < 4'(`ACC_BITS_FULL))
    |=> st.busy)
    else $error("full conversion ended early");
endmodule // acc_ctrl

// ===== acc_sar_model.sv
// acc_sar_model.sv: stand-in for the analog sampler and comparator.
// assumes hold_i comes from the control block on the same clock.
`timescale 1ns/1ns
module acc_sar_model (
  // clock and sampler control
  input wire logic core_clk_i,
  input wire logic hold_i,
  input wire logic level_i,
  // comparator decision
  output logic sar_bit_o
);
  logic held = 1'b0;
  logic hold_q = 1'b0;
  logic tog = 1'b0;
  always @(posedge core_clk_i) begin
    hold_q <= hold_i;
    tog <= ~tog;
    if (hold_i && !hold_q) begin
      held <= level_i;
    end
  end
  // tracking: no valid decision outside a conversion
  assign sar_bit_o = hold_i ? held : tog;
endmodule // acc_sar_model

// ===== tb_top.sv
// tb_top.sv: self-checking bench for the converter control block.
// assumes acc_pkg, acc_ctrl and acc_sar_model are compiled first.
`timescale 1ns/1ns
module tb_top;
  import acc_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b0;
  logic cs_n = 1'b1;
  logic rc = 1'b1;
  logic wf = 1'b1;
  logic sel = 1'b0;
  logic lvl = 1'b0;
  logic sb, busy, hold;
  acc_word_t data, oe, res;
  int miscompares = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic [31:0] seed = 32'hc8e1b1fd;
  always #5 clk = ~clk;
  acc_ctrl i_acc_ctrl (.core_clk_i(clk), .rst_n_i(rst_n), .chip_enable_i(ce),
    .chip_select_n_i(cs_n), .read_convert_i(rc), .width_full_i(wf),
    .byte_length_select_i(sel), .sar_bit_i(sb), .conversion_busy_flag_o(busy),
    .hold_o(hold), .data_o(data), .data_oe_o(oe));
  acc_sar_model i_acc_sar_model (.core_clk_i(clk), .hold_i(hold), .level_i(lvl),
    .sar_bit_o(sb));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
  endfunction
  task automatic chk(input string w, input acc_word_t e, input acc_word_t g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // one conversion; flip changes length by a second start while busy
  task automatic conv(input int how, input logic l8, input logic flip);
    int n;
    int e;
    logic lv;
    ce = (how != 0);
    cs_n = (how == 1);
    rc = (how == 2);
    sel = l8;
    lv = lvl;
    repeat (6) @(negedge clk);
    ce = 1'b1;
    cs_n = 1'b0;
    rc = 1'b0;
    n = 0;
    while (busy !== 1'b1 && n < 4) begin
      @(negedge clk);
      n++;
    end
    chk("busy rise", 12'h001, 12'(busy));
    repeat (100 - n) @(negedge clk);
    // read raised early, while still busy
    rc = 1'b1;
    lvl = ~lvl;
    repeat (8) @(negedge clk);
    chk("oe busy", 12'h000, oe);
    chk("hold", 12'h001, 12'(hold));
    sel = l8 ^ flip;
    rc = 1'b0;
    n = 108;
    while (busy === 1'b1 && n < 1300) begin
      @(negedge clk);
      n++;
      seed = lfsr(seed);
      if (n > 120) sel = seed[3];
    end
    e = (l8 ^ flip) ? 760 : 1140;
    chk("busy len", 12'(e), 12'((n >= e && n <= e + 6) ? e : n));
    chk("hold end", 12'h000, 12'(hold));
    res = (l8 ^ flip) ? {{8{lv}}, 4'h8} : {12{lv}};
    ce = 1'b0;
    cs_n = 1'b1;
    rc = 1'b1;
    repeat (141) @(negedge clk);
  endtask
  task automatic rd(input logic w, input logic s);
    wf = w;
    sel = s;
    ce = 1'b1;
    cs_n = 1'b0;
    repeat (4) @(negedge clk);
    chk("oe", w ? 12'hfff : (s ? 12'h0ff : 12'hff0), oe);
    chk("data", w ? res : (s ? {8'h0, res[3:0]} : {res[11:4], 4'h0}), data & oe);
  endtask
  task automatic swap();
    sel = ~sel;
    repeat (6) begin
      @(negedge clk);
      chk("overlap", 12'h000, 12'(|oe[11:8] & |oe[3:0]));
    end
  endtask
  // watchdog against a hung handshake
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    chk("busy idle", 12'h000, 12'(busy));
    chk("oe idle", 12'h000, oe);
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      lvl = seed[0];
      conv(i % 3, i[0], seed[2] | (i == 3));
      rd(1'b1, seed[5]);
      rd(1'b0, 1'b0);
      swap();
      rd(1'b0, 1'b1);
      swap();
      ce = 1'b0;
      repeat (4) @(negedge clk);
      chk("oe off", 12'h000, oe);
      cs_n = 1'b1;
    end
    tally_and_finish();
  end
endmodule // tb_top
